//--- porg_map.svh
// Function
// - The supply-low guard is asserted whenever the core, any I/O bank or the pre-driver supply is below threshold.
// - While the supply-low guard is asserted, every guarded user pin's output buffer is forced off.
// - The configuration-done, chip-enable-out and configuration-status pins bypass the supply-low guard.
// - User output buffers stay disabled throughout power-up and power-down, whatever the supply ramp order.
// - All user I/O pins stay tri-stated until configuration is complete and user mode is entered.
// - The whole logic is held in reset until every monitored supply has stabilised during power-up.
// - Configuration is not triggered until all eight I/O bank supplies, the pre-driver and the core supply are good.
// - In user mode the core supply is still watched, and a sag below operating level resets the whole device.
// - A power-on reset event is valid only if all supplies reach operating range within 100 ms of power applied.
// - The delay-select input picks the reset delay: 100 ms when low, 12 ms when high.
`ifndef PORG_MAP_SVH
`define PORG_MAP_SVH

// ==================================================
// Clock and timing
`define PORG_CLK_HZ        100000000
`define PORG_CYC_PER_MS    (`PORG_CLK_HZ / 1000)
`define PORG_POR_LONG_MS   100
`define PORG_POR_SHORT_MS  12
`define PORG_RISE_MAX_MS   100
`define PORG_POR_LONG_CYC  (`PORG_POR_LONG_MS * `PORG_CYC_PER_MS)
`define PORG_POR_SHORT_CYC (`PORG_POR_SHORT_MS * `PORG_CYC_PER_MS)
`define PORG_RISE_MAX_CYC  (`PORG_RISE_MAX_MS * `PORG_CYC_PER_MS)

// ==================================================
// Widths and field positions
`define PORG_IO_BANKS      8
`define PORG_CNT_W         24
`define PORG_USER_PINS     16
`define PORG_CFG_PINS      3
`define PORG_CFG_DONE_BIT  0
`define PORG_CFG_CEO_BIT   1
`define PORG_CFG_STAT_BIT  2
`define PORG_SUP_W         (`PORG_IO_BANKS + 2)

`endif

//--- porg_pkg.sv
`include "porg_map.svh"

package porg_pkg;

   // ==================================================
   // Supply-good bundle
   typedef struct packed {
      logic                        core;
      logic [`PORG_IO_BANKS-1:0]   io_bank;
      logic                        predriver;
   } porg_supply_s;

   // ==================================================
   // Sequencer states
   typedef enum logic [2:0] {
      PORG_OFF    = 3'b000,
      PORG_RAMP   = 3'b001,
      PORG_DELAY  = 3'b010,
      PORG_CONFIG = 3'b011,
      PORG_USER   = 3'b100,
      PORG_FAULT  = 3'b101
   } porg_state_e;

endpackage

//--- porg_sync.sv
`timescale 1ns/1ps

// ==================================================
// Two-stage synchroniser for pin levels
module porg_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule

//--- porg_top.sv
`timescale 1ns/1ps
`include "porg_map.svh"

// ==================================================
// Power-on reset sequencer and output guard
module porg_top #(
   parameter int USER_PINS     = `PORG_USER_PINS,
   parameter int POR_LONG_CYC  = `PORG_POR_LONG_CYC,
   parameter int POR_SHORT_CYC = `PORG_POR_SHORT_CYC,
   parameter int RISE_MAX_CYC  = `PORG_RISE_MAX_CYC
) (
   input  wire logic                        CLK_SYS_I,
   input  wire logic                        NRST_I,
   input  wire logic                        CORE_SUPPLY_GOOD_I,
   input  wire logic [`PORG_IO_BANKS-1:0]   IO_BANK_SUPPLY_GOOD_I,
   input  wire logic                        PREDRIVER_SUPPLY_GOOD_I,
   input  wire logic                        RESET_DELAY_SELECT_I,
   input  wire logic                        CONFIG_DONE_I,
   input  wire logic [USER_PINS-1:0]        USER_OE_I,
   input  wire logic [`PORG_CFG_PINS-1:0]   CFG_PIN_OE_I,
   output logic      [USER_PINS-1:0]        USER_OE_O,
   output logic      [`PORG_CFG_PINS-1:0]   CFG_PIN_OE_O,
   output logic                             SUPPLY_LOW_GUARD_O,
   output logic                             DEVICE_RESET_N_O,
   output logic                             CONFIG_START_O,
   output logic                             USER_MODE_O,
   output logic                             POR_FAULT_O
);

   localparam logic [`PORG_CNT_W-1:0] LONG_CNT  = `PORG_CNT_W'(POR_LONG_CYC - 1);
   localparam logic [`PORG_CNT_W-1:0] SHORT_CNT = `PORG_CNT_W'(POR_SHORT_CYC - 1);
   localparam logic [`PORG_CNT_W-1:0] RISE_CNT  = `PORG_CNT_W'(RISE_MAX_CYC - 1);

   // ==================================================
   // Pin synchronisation
   logic [`PORG_SUP_W-1:0] sup_raw;
   logic [`PORG_SUP_W-1:0] sup_sync;
   logic                   sel_sync;
   porg_pkg::porg_supply_s sup;

   assign sup_raw = {CORE_SUPPLY_GOOD_I, IO_BANK_SUPPLY_GOOD_I, PREDRIVER_SUPPLY_GOOD_I};

   porg_sync #(
      .WIDTH (`PORG_SUP_W + 1)
   ) u_sync (
      .clk_i  (CLK_SYS_I),
      .nrst_i (NRST_I),
      .d_i    ({sup_raw, RESET_DELAY_SELECT_I}),
      .q_o    ({sup_sync, sel_sync})
   );

   assign sup = porg_pkg::porg_supply_s'(sup_sync);

   function automatic logic all_good(input porg_pkg::porg_supply_s s);
      all_good = s.core & (&s.io_bank) & s.predriver;
   endfunction

   function automatic logic any_good(input porg_pkg::porg_supply_s s);
      any_good = s.core | (|s.io_bank) | s.predriver;
   endfunction

   function automatic logic [`PORG_CNT_W-1:0] cnt_inc(input logic [`PORG_CNT_W-1:0] c);
      cnt_inc = c + `PORG_CNT_W'(1);
   endfunction

   logic sup_ok;
   logic sup_any;

   assign sup_ok  = all_good(sup);
   assign sup_any = any_good(sup);

   // ==================================================
   // Sequencer
   porg_pkg::porg_state_e  state_ff;
   porg_pkg::porg_state_e  nxt_state;
   logic [`PORG_CNT_W-1:0] cnt_ff;
   logic [`PORG_CNT_W-1:0] nxt_cnt;
   logic [`PORG_CNT_W-1:0] delay_end;

   assign delay_end = sel_sync ? SHORT_CNT : LONG_CNT;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = '0;
      case (state_ff)
         porg_pkg::PORG_OFF: begin
            if (sup_ok) begin
               nxt_state = porg_pkg::PORG_DELAY;
            end else if (sup_any) begin
               nxt_state = porg_pkg::PORG_RAMP;
            end
         end
         porg_pkg::PORG_RAMP: begin
            if (sup_ok) begin
               nxt_state = porg_pkg::PORG_DELAY;
            end else if (!sup_any) begin
               nxt_state = porg_pkg::PORG_OFF;
            end else if (cnt_ff == RISE_CNT) begin
               nxt_state = porg_pkg::PORG_FAULT;
            end else begin
               nxt_cnt = cnt_inc(cnt_ff);
            end
         end
         porg_pkg::PORG_DELAY: begin
            if (!sup_ok) begin
               nxt_cnt = '0;
            end else if (cnt_ff >= delay_end) begin
               nxt_state = porg_pkg::PORG_CONFIG;
            end else begin
               nxt_cnt = cnt_inc(cnt_ff);
            end
         end
         porg_pkg::PORG_CONFIG: begin
            if (!sup_ok) begin
               nxt_state = porg_pkg::PORG_DELAY;
            end else if (CONFIG_DONE_I) begin
               nxt_state = porg_pkg::PORG_USER;
            end
         end
         porg_pkg::PORG_USER: begin
            if (!sup.core) begin
               nxt_state = porg_pkg::PORG_RAMP;
            end
         end
         porg_pkg::PORG_FAULT: begin
            if (!sup_any) begin
               nxt_state = porg_pkg::PORG_OFF;
            end
         end
         default: begin
            nxt_state = porg_pkg::PORG_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         state_ff <= porg_pkg::PORG_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==================================================
   // Rise-window and delay counter
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // ==================================================
   // Reset, trigger and mode outputs
   logic in_user;
   logic in_config;
   logic in_fault;

   assign in_user   = (nxt_state == porg_pkg::PORG_USER);
   assign in_config = (nxt_state == porg_pkg::PORG_CONFIG);
   assign in_fault  = (nxt_state == porg_pkg::PORG_FAULT);

   // Released only once the delay has run out
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         DEVICE_RESET_N_O <= 1'b0;
      end else begin
         DEVICE_RESET_N_O <= in_config || in_user;
      end
   end

   // One pulse on each entry into configuration
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         CONFIG_START_O <= 1'b0;
      end else begin
         CONFIG_START_O <= in_config && (state_ff != porg_pkg::PORG_CONFIG);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         USER_MODE_O <= 1'b0;
      end else begin
         USER_MODE_O <= in_user;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         POR_FAULT_O <= 1'b0;
      end else begin
         POR_FAULT_O <= in_fault;
      end
   end

   // ==================================================
   // Output guard
   logic guard;

   assign guard = !sup_ok;

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         SUPPLY_LOW_GUARD_O <= 1'b1;
      end else begin
         SUPPLY_LOW_GUARD_O <= guard;
      end
   end

   // User buffers off unless in user mode with all supplies good
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         USER_OE_O <= '0;
      end else begin
         USER_OE_O <= (guard || !in_user) ? '0 : USER_OE_I;
      end
   end

   // Config pins exempt from the guard
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         CFG_PIN_OE_O <= '0;
      end else begin
         CFG_PIN_OE_O <= CFG_PIN_OE_I;
      end
   end

endmodule

//--- porg_top_sva.sv
`timescale 1ns/1ps
`include "porg_map.svh"
// ==================================================
// Sequencer checks
module porg_top_sva #(
   parameter int USER_PINS     = `PORG_USER_PINS,
   parameter int POR_LONG_CYC  = `PORG_POR_LONG_CYC,
   parameter int POR_SHORT_CYC = `PORG_POR_SHORT_CYC
) (
   input wire logic                      CLK_SYS_I,
   input wire logic                      NRST_I,
   input wire logic                      CORE_SUPPLY_GOOD_I,
   input wire logic [`PORG_IO_BANKS-1:0] IO_BANK_SUPPLY_GOOD_I,
   input wire logic                      PREDRIVER_SUPPLY_GOOD_I,
   input wire logic                      RESET_DELAY_SELECT_I,
   input wire logic [`PORG_CFG_PINS-1:0] CFG_PIN_OE_I,
   input wire logic [USER_PINS-1:0]      USER_OE_O,
   input wire logic [`PORG_CFG_PINS-1:0] CFG_PIN_OE_O,
   input wire logic                      SUPPLY_LOW_GUARD_O,
   input wire logic                      DEVICE_RESET_N_O,
   input wire logic                      CONFIG_START_O,
   input wire logic                      USER_MODE_O,
   input wire logic                      POR_FAULT_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!NRST_I);
   logic        all_good;
   logic [23:0] run_ff;
   assign all_good = CORE_SUPPLY_GOOD_I & (&IO_BANK_SUPPLY_GOOD_I) & PREDRIVER_SUPPLY_GOOD_I;
   // Consecutive all-good cycles
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I || !all_good) begin
         run_ff <= '0;
      end else begin
         run_ff <= run_ff + 24'h1;
      end
   end
   chk_guard_low: assert property (!all_good [*3] |=> SUPPLY_LOW_GUARD_O)
      else $error("guard not raised");
   chk_user_gate: assert property (SUPPLY_LOW_GUARD_O && $past(SUPPLY_LOW_GUARD_O) |-> USER_OE_O == '0)
      else $error("user pin driven under guard");
   chk_cfg_pass: assert property ($past(NRST_I) |-> CFG_PIN_OE_O == $past(CFG_PIN_OE_I))
      else $error("config pin gated");
   chk_user_only: assert property (!USER_MODE_O && !$past(USER_MODE_O) |-> USER_OE_O == '0)
      else $error("user pin driven outside user mode");
   chk_reset_rise: assert property ($rose(DEVICE_RESET_N_O) |-> CONFIG_START_O && !SUPPLY_LOW_GUARD_O)
      else $error("reset released early");
   chk_start_pulse: assert property (CONFIG_START_O |=> !CONFIG_START_O)
      else $error("start not a pulse");
   chk_brown_out: assert property ((USER_MODE_O && !CORE_SUPPLY_GOOD_I) [*3] |=> !DEVICE_RESET_N_O)
      else $error("no reset on core sag");
   chk_delay_min: assert property ($rose(DEVICE_RESET_N_O) |->
      run_ff >= (RESET_DELAY_SELECT_I ? POR_SHORT_CYC : POR_LONG_CYC))
      else $error("reset delay too short");
   cover property ($rose(USER_MODE_O));
   cover property ($rose(POR_FAULT_O));
   cover property (CONFIG_START_O && RESET_DELAY_SELECT_I);
endmodule

//--- porg_psu.sv
`timescale 1ns/1ps
// ==================================================
// Board supplies: one rail moves toward its target per cycle
module porg_psu (
   input  wire logic                   clk_i,
   input  wire porg_pkg::porg_supply_s target_i,
   output porg_pkg::porg_supply_s      good_o
);
   porg_pkg::porg_supply_s diff;
   assign diff = good_o ^ target_i;
   initial good_o = '0;
   always @(posedge clk_i) begin
      good_o <= good_o ^ (diff & (~diff + 1'b1));
   end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
// ==================================================
// Testbench
module testbench;
   localparam int LONG  = 40;
   localparam int SHORT = 12;
   logic                   clk, nrst, sel, done;
   logic [15:0]            uoe, uoe_o;
   logic [2:0]             coe, coe_o;
   logic                   guard, rst_n, start, umode, fault;
   porg_pkg::porg_supply_s tgt, sup;
   int                     n_errors, n_tests, n;
   int                     row_sel[2] = '{1, 0};
   int                     row_len[2] = '{SHORT, LONG};
   porg_psu u_psu (.clk_i(clk), .target_i(tgt), .good_o(sup));
   porg_top #(.POR_LONG_CYC(LONG), .POR_SHORT_CYC(SHORT), .RISE_MAX_CYC(60)) dut (
      .CLK_SYS_I(clk), .NRST_I(nrst), .CORE_SUPPLY_GOOD_I(sup.core),
      .IO_BANK_SUPPLY_GOOD_I(sup.io_bank), .PREDRIVER_SUPPLY_GOOD_I(sup.predriver),
      .RESET_DELAY_SELECT_I(sel), .CONFIG_DONE_I(done), .USER_OE_I(uoe), .CFG_PIN_OE_I(coe),
      .USER_OE_O(uoe_o), .CFG_PIN_OE_O(coe_o), .SUPPLY_LOW_GUARD_O(guard), .DEVICE_RESET_N_O(rst_n),
      .CONFIG_START_O(start), .USER_MODE_O(umode), .POR_FAULT_O(fault));
   task automatic summarize;
      if (n_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      #1 n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("unexpected %0t %s", $time, msg);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic do_reset;
      cyc(1);
      done <= 1'b0;
      tgt <= '0;
      cyc(12);
      nrst <= 1'b0;
      cyc(5);
      nrst <= 1'b1;
   endtask
   task automatic wait_start(output int k);
      k = 0;
      while (start !== 1'b1 && k < 500) begin
         @(posedge clk);
         #1 k++;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial begin
      {nrst, sel, done, coe, tgt, n_errors, n_tests} = '0;
      uoe = 16'ha5c3;
      cyc(5);
      nrst <= 1'b1;
      cyc(1);
      chk(guard === 1'b1 && rst_n === 1'b0 && uoe_o === 16'h0, "reset state");
      for (int i = 0; i < 2; i++) begin
         do_reset();
         sel <= row_sel[i][0];
         tgt <= '1;
         wait_start(n);
         chk(n >= row_len[i] + 10 && n <= row_len[i] + 20 && rst_n === 1'b1, "delay");
         cyc(1);
         done <= 1'b1;
         cyc(2);
         chk(umode === 1'b1 && uoe_o === uoe, "user mode");
      end
      cyc(1);
      done <= 1'b0;
      tgt.io_bank[3] <= 1'b0;
      cyc(5);
      chk(guard === 1'b1 && uoe_o === 16'h0 && rst_n === 1'b1, "bank drop");
      cyc(1);
      coe <= 3'h5;
      cyc(2);
      chk(coe_o === 3'h5, "cfg pins");
      cyc(1);
      tgt.io_bank[3] <= 1'b1;
      cyc(6);
      chk(guard === 1'b0 && uoe_o === uoe, "bank back");
      cyc(1);
      tgt.core <= 1'b0;
      cyc(5);
      chk(rst_n === 1'b0 && umode === 1'b0 && uoe_o === 16'h0, "brown-out");
      cyc(1);
      tgt.core <= 1'b1;
      cyc(12);
      tgt.predriver <= 1'b0;
      cyc(1);
      tgt.predriver <= 1'b1;
      wait_start(n);
      chk(n >= LONG, "restart");
      do_reset();
      tgt.core <= 1'b1;
      cyc(40);
      chk(fault === 1'b0 && rst_n === 1'b0, "ramp");
      cyc(41);
      chk(fault === 1'b1 && rst_n === 1'b0, "rise fault");
      cyc(1);
      tgt <= '1;
      cyc(40);
      chk(fault === 1'b1 && rst_n === 1'b0, "fault held");
      cyc(1);
      tgt <= '0;
      cyc(20);
      chk(fault === 1'b0, "fault cleared");
      summarize();
   end
endmodule
bind porg_top porg_top_sva #(.USER_PINS(USER_PINS), .POR_LONG_CYC(POR_LONG_CYC), .POR_SHORT_CYC(POR_SHORT_CYC)) u_sva (
   .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .CORE_SUPPLY_GOOD_I(CORE_SUPPLY_GOOD_I),
   .IO_BANK_SUPPLY_GOOD_I(IO_BANK_SUPPLY_GOOD_I), .PREDRIVER_SUPPLY_GOOD_I(PREDRIVER_SUPPLY_GOOD_I),
   .RESET_DELAY_SELECT_I(RESET_DELAY_SELECT_I), .CFG_PIN_OE_I(CFG_PIN_OE_I), .USER_OE_O(USER_OE_O),
   .CFG_PIN_OE_O(CFG_PIN_OE_O), .SUPPLY_LOW_GUARD_O(SUPPLY_LOW_GUARD_O), .DEVICE_RESET_N_O(DEVICE_RESET_N_O),
   .CONFIG_START_O(CONFIG_START_O), .USER_MODE_O(USER_MODE_O), .POR_FAULT_O(POR_FAULT_O));
